/* File: hdl/srpd_top.sv */
// Security register and power-down command logic
`timescale 1ns/100ps
// Function
// RULE1: Program needs enable latch
// RULE2: 42H, address, data bytes
// RULE3: Select rise starts program, busy flag
// RULE4: Enable latch cleared by cycle end
// RULE5: Lock bit blocks programming
// RULE6: Upper address bits zero
// RULE7: 48H, address, dummy; rising sampling
// RULE8: Read data changes on falling edge
// RULE9: Read address wraps at 1FFH
// RULE10: B9H needs exactly eight bits
// RULE11: Power-down entered after entry delay
// RULE12: Power-down ignores all but release, reset
// RULE13: Power-down refused while busy
// RULE14: Idle deselect gives standby
// RULE15: Power-up starts in standby
// RULE16: ABH release waits release delay
// RULE17: ABH, dummies, identification repeats
// RULE18: Release ignored while busy
// RULE19: Host waits before first use
// RULE20: Erased bytes FFH, status zero
// RULE21: Lock bit stays set
// RULE22: Partial data byte abandons program
module srpd_top #(
  parameter logic [7:0]  ID_VALUE    = 8'h5C,  // Arbitrary value
  parameter logic [15:0] PROG_CYCLES = srpd_pkg::PROG_CYCLES
) (
  // System clock and reset
  input  wire logic CLK,
  input  wire logic NRST,
  // Serial link
  input  wire logic SCLK,
  input  wire logic CS_N,
  input  wire logic SI,
  output logic      SO,
  output logic      SO_OE,
  // Device context
  input  wire logic EXT_BUSY,
  input  wire logic SOFT_RESET,
  input  wire logic LOCK_FUSE,
  input  wire logic LOCK_BLOW,
  // Status
  output logic      WRITE_IN_PROGRESS,
  output logic      WRITE_ENABLE_LATCH,
  output logic      SECURITY_LOCK_BIT,
  output logic      DEEP_POWER_DOWN,
  output logic      STANDBY
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic                       link_rst_n;
  logic [srpd_pkg::CNT_W-1:0] cnt_ff;
  logic [srpd_pkg::CNT_W-1:0] nxt_cnt;
  logic [2:0]                 bit_ff;
  logic [2:0]                 nxt_bit;
  logic [23:0]                sh_ff;
  logic [23:0]                nxt_sh;
  logic [7:0]                 op_ff;
  logic [7:0]                 nxt_op;
  srpd_pkg::srpd_frame_s      frame_ff;
  srpd_pkg::srpd_frame_s      nxt_frame;
  srpd_pkg::srpd_out_e        out_ff;
  srpd_pkg::srpd_out_e        nxt_out;
  logic [srpd_pkg::SEC_AW-1:0] rd_addr_ff;
  logic [srpd_pkg::SEC_AW-1:0] nxt_rd_addr;
  logic [srpd_pkg::SEC_AW-1:0] wr_addr_ff;
  logic [srpd_pkg::SEC_AW-1:0] nxt_wr_addr;
  logic [7:0]                 buf_ff [srpd_pkg::SEC_BYTES];
  logic [7:0]                 nxt_buf [srpd_pkg::SEC_BYTES];
  logic [srpd_pkg::SEC_BYTES-1:0] val_ff;
  logic [srpd_pkg::SEC_BYTES-1:0] nxt_val;
  logic                       tog_ff;
  logic                       nxt_tog;
  logic                       so_ff;
  logic                       nxt_so;
  logic                       oe_ff;
  logic                       nxt_oe;
  logic                       blocked_s;
  logic                       busy_s;
  logic [7:0]                 byte_in;
  logic [23:0]                addr_in;

  srpd_pkg::srpd_state_e      state_ff;
  srpd_pkg::srpd_state_e      nxt_state;
  logic [7:0]                 mem_ff [srpd_pkg::SEC_BYTES];
  logic [7:0]                 nxt_mem [srpd_pkg::SEC_BYTES];
  logic                       wel_ff;
  logic                       nxt_wel;
  logic                       wip_ff;
  logic                       nxt_wip;
  logic                       lock_ff;
  logic                       nxt_lock;
  logic                       dpd_ff;
  logic                       nxt_dpd;
  logic                       stby_ff;
  logic                       nxt_stby;
  logic                       blocked_ff;
  logic                       nxt_blocked;
  logic                       busy_ff;
  logic                       nxt_busy;
  logic                       cs_prev_ff;
  logic                       seen_ff;
  logic                       nxt_seen;
  logic                       cs_s;
  logic                       tog_s;
  logic                       cs_rise;
  logic                       busy_now;
  logic                       tmr_load;
  logic [srpd_pkg::TMR_W-1:0] tmr_count;
  logic                       tmr_done;

  // --------------------------------------------------------------------------
  // Link side: capture on rising serial clock
  // --------------------------------------------------------------------------
  // Select high resets the frame counters
  assign link_rst_n = NRST & ~CS_N;
  assign byte_in    = {sh_ff[6:0], SI};
  assign addr_in    = {sh_ff[22:0], SI};

  always_comb begin
    nxt_cnt     = (cnt_ff == srpd_pkg::CNT_SAT) ? cnt_ff : cnt_ff + srpd_pkg::CNT_ONE;
    nxt_bit     = bit_ff + srpd_pkg::BIT_ONE;
    nxt_sh      = {sh_ff[22:0], SI};                                       // [RULE7]
    nxt_op      = op_ff;
    nxt_frame   = frame_ff;
    nxt_out     = out_ff;
    nxt_rd_addr = rd_addr_ff;
    nxt_wr_addr = wr_addr_ff;
    nxt_buf     = buf_ff;
    nxt_val     = val_ff;
    nxt_tog     = tog_ff;
    if (cnt_ff == srpd_pkg::CNT_ZERO) begin
      nxt_tog       = ~tog_ff;
      nxt_val       = '0;
      nxt_out       = srpd_pkg::OUT_NONE;
      nxt_frame     = '{kind: srpd_pkg::FR_NONE, addr_ok: 1'b0};
    end
    nxt_frame.kind = srpd_pkg::FR_NONE;
    if (cnt_ff == srpd_pkg::CNT_OPCODE_DONE) begin
      nxt_op = byte_in;
      unique case (byte_in)
        srpd_pkg::OP_WRITE_ENABLE:    nxt_frame.kind = srpd_pkg::FR_WRITE_ENABLE_CMD;
        srpd_pkg::OP_DEEP_POWER_DOWN: nxt_frame.kind = srpd_pkg::FR_DPD;   // [RULE10]
        srpd_pkg::OP_RELEASE_AND_ID: begin
          nxt_frame.kind = srpd_pkg::FR_REL;
          if (!busy_s) begin
            nxt_out = srpd_pkg::OUT_ID;                                    // [RULE18]
          end
        end
        srpd_pkg::OP_READ_SEC: begin
          if (!blocked_s) begin
            nxt_out = srpd_pkg::OUT_SEC;                                   // [RULE12]
          end
        end
        default: nxt_frame.kind = srpd_pkg::FR_NONE;
      endcase
    end else if (cnt_ff > srpd_pkg::CNT_OPCODE_DONE && frame_ff.kind == srpd_pkg::FR_REL) begin
      nxt_frame.kind = srpd_pkg::FR_REL;
    end else if (op_ff == srpd_pkg::OP_PROG_SEC && bit_ff == srpd_pkg::BIT_LAST &&
                 cnt_ff >= srpd_pkg::CNT_DATA1_DONE) begin
      nxt_frame.kind = srpd_pkg::FR_PROG;                                  // [RULE22]
    end
    if (cnt_ff == srpd_pkg::CNT_ADDR_DONE) begin
      nxt_frame.addr_ok = (addr_in[23:srpd_pkg::SEC_AW] == srpd_pkg::SEC_ADDR_HI);  // [RULE6]
      nxt_rd_addr       = addr_in[srpd_pkg::SEC_AW-1:0];
      nxt_wr_addr       = addr_in[srpd_pkg::SEC_AW-1:0];
    end
    if (out_ff == srpd_pkg::OUT_SEC && cnt_ff == srpd_pkg::CNT_SAT && bit_ff == srpd_pkg::BIT_LAST) begin
      nxt_rd_addr = rd_addr_ff + srpd_pkg::SEC_AW'(1);                     // [RULE9]
    end
    if (op_ff == srpd_pkg::OP_PROG_SEC && bit_ff == srpd_pkg::BIT_LAST &&
        cnt_ff >= srpd_pkg::CNT_DATA1_DONE) begin
      nxt_buf[wr_addr_ff] = byte_in;
      nxt_val[wr_addr_ff] = 1'b1;
      nxt_wr_addr = {wr_addr_ff[srpd_pkg::SEC_AW-1], wr_addr_ff[srpd_pkg::PAGE_AW-1:0] + srpd_pkg::PAGE_ONE};
    end
  end

  always_ff @(posedge SCLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt_ff <= srpd_pkg::CNT_ZERO;
      bit_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      bit_ff <= nxt_bit;
    end
  end

  always_ff @(posedge SCLK or negedge NRST) begin
    if (!NRST) begin
      sh_ff      <= '0;
      op_ff      <= '0;
      frame_ff   <= '{kind: srpd_pkg::FR_NONE, addr_ok: 1'b0};
      out_ff     <= srpd_pkg::OUT_NONE;
      rd_addr_ff <= '0;
      wr_addr_ff <= '0;
      buf_ff     <= '{default: srpd_pkg::ERASED_BYTE};
      val_ff     <= '0;
      tog_ff     <= 1'b0;
    end else begin
      sh_ff      <= nxt_sh;
      op_ff      <= nxt_op;
      frame_ff   <= nxt_frame;
      out_ff     <= nxt_out;
      rd_addr_ff <= nxt_rd_addr;
      wr_addr_ff <= nxt_wr_addr;
      buf_ff     <= nxt_buf;
      val_ff     <= nxt_val;
      tog_ff     <= nxt_tog;
    end
  end

  // --------------------------------------------------------------------------
  // Link side: output on falling serial clock
  // --------------------------------------------------------------------------
  // Array changes only at program end, reads held off
  always_comb begin
    nxt_so = 1'b0;
    nxt_oe = 1'b0;
    if (out_ff == srpd_pkg::OUT_SEC && cnt_ff == srpd_pkg::CNT_SAT) begin
      nxt_oe = 1'b1;
      nxt_so = mem_ff[rd_addr_ff][srpd_pkg::BIT_LAST - bit_ff];            // [RULE8]
    end else if (out_ff == srpd_pkg::OUT_ID && cnt_ff >= srpd_pkg::CNT_ID_OUT) begin
      nxt_oe = 1'b1;
      nxt_so = ID_VALUE[srpd_pkg::BIT_LAST - bit_ff];                      // [RULE17]
    end
  end

  always_ff @(negedge SCLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      so_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      so_ff <= nxt_so;
      oe_ff <= nxt_oe;
    end
  end

  // --------------------------------------------------------------------------
  // Crossings
  // --------------------------------------------------------------------------
  srpd_sync3 #(.RST_VAL(1'b1)) u_sync_cs (.clk(CLK), .nrst(NRST), .d(CS_N), .q(cs_s));
  srpd_sync3 #(.RST_VAL(1'b0)) u_sync_tog (.clk(CLK), .nrst(NRST), .d(tog_ff), .q(tog_s));
  srpd_sync3 #(.RST_VAL(1'b1)) u_sync_blk (.clk(SCLK), .nrst(NRST), .d(blocked_ff), .q(blocked_s));
  srpd_sync3 #(.RST_VAL(1'b1)) u_sync_busy (.clk(SCLK), .nrst(NRST), .d(busy_ff), .q(busy_s));

  srpd_timer u_timer (
    .clk   (CLK),
    .nrst  (NRST),
    .load  (tmr_load),
    .count (tmr_count),
    .done  (tmr_done)
  );

  // --------------------------------------------------------------------------
  // System side: execution and mode control
  // --------------------------------------------------------------------------
  // Frame stable once deselected; toggle marks a new frame
  assign cs_rise  = cs_s & ~cs_prev_ff;
  assign busy_now = (state_ff == srpd_pkg::ST_PROG) | EXT_BUSY;

  always_comb begin
    nxt_state = state_ff;
    nxt_wel   = wel_ff;
    nxt_mem   = mem_ff;
    nxt_seen  = seen_ff;
    nxt_lock  = lock_ff | LOCK_FUSE | LOCK_BLOW;                           // [RULE21]
    tmr_load  = 1'b0;
    tmr_count = PROG_CYCLES;
    if (cs_rise && tog_s != seen_ff) begin
      nxt_seen = tog_s;
      unique case (frame_ff.kind)
        srpd_pkg::FR_WRITE_ENABLE_CMD: begin
          if (state_ff == srpd_pkg::ST_STANDBY && !busy_now) begin
            nxt_wel = 1'b1;
          end
        end
        srpd_pkg::FR_PROG: begin
          if (state_ff == srpd_pkg::ST_STANDBY && !busy_now && wel_ff &&   // [RULE1] [RULE12]
              !lock_ff && frame_ff.addr_ok) begin                          // [RULE5]
            nxt_state = srpd_pkg::ST_PROG;                                 // [RULE3]
            tmr_load  = 1'b1;
          end
        end
        srpd_pkg::FR_DPD: begin
          if (state_ff == srpd_pkg::ST_STANDBY && !busy_now) begin         // [RULE13]
            nxt_state = srpd_pkg::ST_DPD_ENTER;
            tmr_load  = 1'b1;
            tmr_count = srpd_pkg::DPD_CYCLES;
          end
        end
        srpd_pkg::FR_REL: begin
          if (!busy_now && (state_ff == srpd_pkg::ST_DPD ||                // [RULE18]
                            state_ff == srpd_pkg::ST_DPD_ENTER)) begin
            nxt_state = srpd_pkg::ST_RELEASE;                              // [RULE16]
            tmr_load  = 1'b1;
            tmr_count = srpd_pkg::RELEASE_CYCLES;
          end
        end
        default: nxt_state = state_ff;
      endcase
    end
    if (tmr_done && !tmr_load) begin
      unique case (state_ff)
        srpd_pkg::ST_PROG: begin
          nxt_state = srpd_pkg::ST_STANDBY;
          nxt_wel   = 1'b0;                                                // [RULE4]
          for (int i = 0; i < srpd_pkg::SEC_BYTES; i++) begin
            if (val_ff[i]) begin
              nxt_mem[i] = mem_ff[i] & buf_ff[i];
            end
          end
        end
        srpd_pkg::ST_DPD_ENTER: nxt_state = srpd_pkg::ST_DPD;              // [RULE11]
        srpd_pkg::ST_RELEASE:   nxt_state = srpd_pkg::ST_STANDBY;
        default:                nxt_state = state_ff;
      endcase
    end
    if (SOFT_RESET && state_ff != srpd_pkg::ST_PROG) begin
      nxt_state = srpd_pkg::ST_STANDBY;
    end
    nxt_wip     = (nxt_state == srpd_pkg::ST_PROG) | EXT_BUSY;            // [RULE3]
    nxt_dpd     = (nxt_state == srpd_pkg::ST_DPD);
    nxt_stby    = (nxt_state == srpd_pkg::ST_STANDBY) & cs_s & ~EXT_BUSY; // [RULE14]
    nxt_blocked = (nxt_state != srpd_pkg::ST_STANDBY) | EXT_BUSY;
    nxt_busy    = nxt_wip;
  end

  // Power-up: standby, erased area, status clear
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_ff   <= srpd_pkg::ST_STANDBY;                                  // [RULE15]
      mem_ff     <= '{default: srpd_pkg::ERASED_BYTE};                     // [RULE20]
      wel_ff     <= 1'b0;
      wip_ff     <= 1'b0;
      lock_ff    <= 1'b0;
      dpd_ff     <= 1'b0;
      stby_ff    <= 1'b0;
      blocked_ff <= 1'b1;
      busy_ff    <= 1'b0;
      cs_prev_ff <= 1'b1;
      seen_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      mem_ff     <= nxt_mem;
      wel_ff     <= nxt_wel;
      wip_ff     <= nxt_wip;
      lock_ff    <= nxt_lock;
      dpd_ff     <= nxt_dpd;
      stby_ff    <= nxt_stby;
      blocked_ff <= nxt_blocked;
      busy_ff    <= nxt_busy;
      cs_prev_ff <= cs_s;
      seen_ff    <= nxt_seen;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign SO                 = so_ff;
  assign SO_OE              = oe_ff;
  assign WRITE_IN_PROGRESS  = wip_ff;
  assign WRITE_ENABLE_LATCH = wel_ff;
  assign SECURITY_LOCK_BIT  = lock_ff;
  assign DEEP_POWER_DOWN    = dpd_ff;
  assign STANDBY            = stby_ff;

endmodule : srpd_top

/* File: hdl/srpd_pkg.sv */
// Constants and types of the command logic
package srpd_pkg;

  // --------------------------------------------------------------------------
  // Opcodes
  // --------------------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
  localparam logic [7:0] OP_PROG_SEC        = 8'h42;
  localparam logic [7:0] OP_READ_SEC        = 8'h48;
  localparam logic [7:0] OP_DEEP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_RELEASE_AND_ID  = 8'hAB;

  // --------------------------------------------------------------------------
  // Frame layout, in rising serial clock edges seen
  // --------------------------------------------------------------------------
  localparam int         CNT_W           = 6;
  localparam logic [5:0] CNT_ZERO        = 6'h00;
  localparam logic [5:0] CNT_OPCODE_DONE = 6'h07;
  localparam logic [5:0] CNT_ADDR_DONE   = 6'h1F;
  localparam logic [5:0] CNT_DATA1_DONE  = 6'h27;
  localparam logic [5:0] CNT_ID_OUT      = 6'h20;
  localparam logic [5:0] CNT_SAT         = 6'h28;
  localparam logic [5:0] CNT_ONE         = 6'h01;
  localparam logic [2:0] BIT_LAST        = 3'h7;
  localparam logic [2:0] BIT_ONE         = 3'h1;

  // --------------------------------------------------------------------------
  // Security register area
  // --------------------------------------------------------------------------
  localparam int          SEC_AW      = 9;
  localparam int          SEC_BYTES   = 512;
  localparam int          PAGE_AW     = 8;
  localparam logic [7:0]  PAGE_ONE    = 8'h01;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;
  localparam logic [14:0] SEC_ADDR_HI = 15'h0000;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          T_PROG_NS      = 600000;
  localparam int          T_DPD_ENTRY_NS = 3000;
  localparam int          T_RELEASE_NS   = 8000;
  localparam int          TMR_W          = 16;
  localparam logic [15:0] PROG_CYCLES    = 16'((T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] DPD_CYCLES     = 16'((T_DPD_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] RELEASE_CYCLES = 16'((T_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {FR_NONE, FR_WRITE_ENABLE_CMD, FR_PROG, FR_DPD, FR_REL} srpd_kind_e;
  typedef enum logic [1:0] {OUT_NONE, OUT_SEC, OUT_ID} srpd_out_e;
  typedef enum logic [2:0] {ST_STANDBY, ST_PROG, ST_DPD_ENTER, ST_DPD, ST_RELEASE} srpd_state_e;

  typedef struct packed {
    srpd_kind_e kind;
    logic       addr_ok;
  } srpd_frame_s;

endpackage : srpd_pkg

/* File: hdl/srpd_sync3.sv */
// Three-stage synchroniser
`timescale 1ns/100ps
module srpd_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  // Destination clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Level in and out
  input  wire logic d,
  output logic      q
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic q_ff;
  logic nxt_q;

  always_comb begin
    nxt_q = (s2_ff == s3_ff) ? s3_ff : q_ff;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      q_ff  <= RST_VAL;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff  <= nxt_q;
    end
  end

  assign q = q_ff;

endmodule : srpd_sync3

/* File: hdl/srpd_timer.sv */
// Loadable down counter with done pulse
`timescale 1ns/100ps
module srpd_timer (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // Control
  input  wire logic                       load,
  input  wire logic [srpd_pkg::TMR_W-1:0] count,
  output logic                            done
);

  logic [srpd_pkg::TMR_W-1:0] cnt_ff;
  logic [srpd_pkg::TMR_W-1:0] nxt_cnt;
  logic                       done_ff;
  logic                       nxt_done;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    if (load) begin
      nxt_cnt = count;
    end else if (cnt_ff != '0) begin
      nxt_cnt  = cnt_ff - srpd_pkg::TMR_W'(1);
      nxt_done = (cnt_ff == srpd_pkg::TMR_W'(1));
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;

endmodule : srpd_timer

/* File: verif/srpd_chk.sv */
// Port assertions of the command logic
`timescale 1ns/100ps
module srpd_chk #(
  parameter logic [15:0] PROG_CYCLES = srpd_pkg::PROG_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Link and context
  input wire logic CS_N,
  input wire logic SO_OE,
  input wire logic EXT_BUSY,
  // Status
  input wire logic WRITE_IN_PROGRESS,
  input wire logic WRITE_ENABLE_LATCH,
  input wire logic SECURITY_LOCK_BIT,
  input wire logic DEEP_POWER_DOWN,
  input wire logic STANDBY
);
  // --------------------------------------------------------------------------
  // Cycle counters
  // --------------------------------------------------------------------------
  logic [15:0] wip_cnt_ff, nxt_wip_cnt, cs_cnt_ff, nxt_cs_cnt;
  always_comb begin
    nxt_wip_cnt = WRITE_IN_PROGRESS ? wip_cnt_ff + 16'h0001 : 16'h0000;
    nxt_cs_cnt  = CS_N ? cs_cnt_ff + {15'h0000, ~&cs_cnt_ff} : 16'h0000;
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wip_cnt_ff <= 16'h0000;
      cs_cnt_ff  <= 16'h0000;
    end else begin
      wip_cnt_ff <= nxt_wip_cnt;
      cs_cnt_ff  <= nxt_cs_cnt;
    end
  end
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  property p_wel_needed; $rose(WRITE_IN_PROGRESS) && !EXT_BUSY && !$past(EXT_BUSY) |-> $past(WRITE_ENABLE_LATCH);
  endproperty
  a_wel_needed: assert property (p_wel_needed) else $error("program without enable latch");
  property p_wip_len; $fell(WRITE_IN_PROGRESS) && !$past(EXT_BUSY, 3) |-> wip_cnt_ff >= PROG_CYCLES; endproperty
  a_wip_len: assert property (p_wip_len) else $error("program cycle too short");
  property p_wel_clear; $fell(WRITE_IN_PROGRESS) && !$past(EXT_BUSY, 3) |-> !WRITE_ENABLE_LATCH; endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("enable latch set at cycle end");
  property p_lock_block; $rose(WRITE_IN_PROGRESS) && !EXT_BUSY && !$past(EXT_BUSY) |-> !$past(SECURITY_LOCK_BIT);
  endproperty
  a_lock_block: assert property (p_lock_block) else $error("program while locked");
  property p_lock_sticky; SECURITY_LOCK_BIT |=> SECURITY_LOCK_BIT; endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");
  property p_so_release; CS_N && $past(CS_N) |-> !SO_OE; endproperty
  a_so_release: assert property (p_so_release) else $error("output driven deselected");
  property p_dpd_entry; $rose(DEEP_POWER_DOWN) |-> cs_cnt_ff >= srpd_pkg::DPD_CYCLES; endproperty
  a_dpd_entry: assert property (p_dpd_entry) else $error("power-down entered early");
  property p_dpd_standby; DEEP_POWER_DOWN |-> !STANDBY; endproperty
  a_dpd_standby: assert property (p_dpd_standby) else $error("standby in power-down");
  property p_dpd_no_wel; $rose(WRITE_ENABLE_LATCH) |-> !$past(DEEP_POWER_DOWN); endproperty
  a_dpd_no_wel: assert property (p_dpd_no_wel) else $error("enable accepted in power-down");
  c_prog: cover property ($fell(WRITE_IN_PROGRESS));
  c_dpd: cover property ($rose(DEEP_POWER_DOWN));
  c_read: cover property ($rose(SO_OE));
endmodule : srpd_chk
bind srpd_top srpd_chk #(.PROG_CYCLES(PROG_CYCLES)) srpd_chk_inst (.CLK(CLK), .NRST(NRST), .CS_N(CS_N),
  .SO_OE(SO_OE), .EXT_BUSY(EXT_BUSY), .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS),
  .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .SECURITY_LOCK_BIT(SECURITY_LOCK_BIT),
  .DEEP_POWER_DOWN(DEEP_POWER_DOWN), .STANDBY(STANDBY));

/* File: verif/srpd_host.sv */
// Behavioural host serial controller driving the command link
`timescale 1ns/100ps
module srpd_host (
  // Link to the device
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end
  task sel;
    #3.3 cs_n = 1'b0;
    #7.5;
  endtask : sel
  task xbit(input logic b, output logic r);
    si = b;
    #7.5 sclk = 1'b1;
    r = so;
    #7.5 sclk = 1'b0;
  endtask : xbit
  task xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) xbit(tx[i], rx[i]);
  endtask : xbyte
  task desel;
    #7.5 cs_n = 1'b1;
    si = ~si;
    #200;
  endtask : desel
  task hdr(input logic [7:0] op, input logic [23:0] a);
    logic [7:0] r;
    sel();
    xbyte(op, r);
    for (int i = 2; i >= 0; i--) xbyte(a[i*8 +: 8], r);
  endtask : hdr
  task cmd(input logic [7:0] op);
    logic [7:0] r;
    sel();
    xbyte(op, r);
    desel();
  endtask : cmd
endmodule : srpd_host

/* File: verif/tb_top.sv */
// Self-checking bench of the command logic
`timescale 1ns/100ps
module tb_top;
  localparam logic [7:0] ID_EXP = 8'h5C;  // Arbitrary value
  logic       clk, nrst, sclk, cs_n, si, so, so_oe, ext_busy, lock_blow, write_in_progress, write_enable_latch, lock, dpd, stby, b, soft_rst, fuse;
  logic [7:0] st, r;
  int         mismatches, checks;
  assign st = {3'h0, stby, dpd, lock, write_enable_latch, write_in_progress};
  srpd_top #(.ID_VALUE(ID_EXP), .PROG_CYCLES(16'h0014)) srpd_top_inst (.CLK(clk), .NRST(nrst), .SCLK(sclk),
    .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe), .EXT_BUSY(ext_busy), .SOFT_RESET(soft_rst), .LOCK_FUSE(fuse),
    .LOCK_BLOW(lock_blow), .WRITE_IN_PROGRESS(write_in_progress), .WRITE_ENABLE_LATCH(write_enable_latch), .SECURITY_LOCK_BIT(lock),
    .DEEP_POWER_DOWN(dpd), .STANDBY(stby));
  srpd_host srpd_host_inst (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask : chk
  task rd(input logic [23:0] a, input logic [7:0] e0, input logic [7:0] e1);
    srpd_host_inst.hdr(8'h48, a);
    srpd_host_inst.xbyte(8'h00, r);
    srpd_host_inst.xbyte(8'h00, r);
    chk("read byte", e0, r);
    chk("output enable", 8'h01, {7'h00, so_oe});
    srpd_host_inst.xbyte(8'h00, r);
    chk("next byte", e1, r);
    srpd_host_inst.desel();
  endtask : rd
  task prog(input logic [23:0] a, input logic [7:0] d, input logic write_enable_cmd);
    if (write_enable_cmd) srpd_host_inst.cmd(8'h06);
    srpd_host_inst.hdr(8'h42, a);
    srpd_host_inst.xbyte(d, r);
    srpd_host_inst.desel();
  endtask : prog
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task t_reset;
    cyc(8);
    chk("reset", 8'h10, st);
    rd(24'h0001FE, 8'hFF, 8'hFF);
    $display("test reset done");
  endtask : t_reset
  task t_prog;
    prog(24'h0001FF, 8'h5A, 1'b0);
    chk("status", 8'h10, st);
    prog(24'h0001FF, 8'h5A, 1'b1);
    chk("busy", 8'h01, st & 8'hFD);
    cyc(30);
    chk("done", 8'h10, st);
    prog(24'h000000, 8'h3C, 1'b1);
    cyc(30);
    rd(24'h0001FF, 8'h5A, 8'h3C);
    $display("test program done");
  endtask : t_prog
  task t_addr;
    prog(24'h000200, 8'h00, 1'b1);
    chk("status", 8'h12, st);
    rd(24'h000000, 8'h3C, 8'hFF);
    $display("test address done");
  endtask : t_addr
  task t_dpd;
    ext_busy = 1'b1;
    srpd_host_inst.cmd(8'hB9);
    cyc(200);
    chk("busy", 8'h03, st);
    ext_busy = 1'b0;
    srpd_host_inst.sel();
    srpd_host_inst.xbyte(8'hB9, r);
    srpd_host_inst.xbit(1'b0, b);
    srpd_host_inst.desel();
    cyc(200);
    chk("nine bit", 8'h12, st);
    srpd_host_inst.cmd(8'hB9);
    cyc(100);
    chk("entry", 8'h02, st);
    cyc(80);
    chk("pd status", 8'h0A, st);
    prog(24'h000000, 8'h00, 1'b1);
    chk("pd status", 8'h0A, st);
    srpd_host_inst.hdr(8'h48, 24'h000000);
    srpd_host_inst.xbyte(8'h00, r);
    srpd_host_inst.xbyte(8'h00, r);
    chk("output enable", 8'h00, {7'h00, so_oe});
    srpd_host_inst.desel();
    srpd_host_inst.cmd(8'hAB);
    chk("release", 8'h02, st);
    cyc(420);
    chk("standby", 8'h12, st);
    srpd_host_inst.hdr(8'hAB, 24'h000000);
    srpd_host_inst.xbyte(8'h00, r);
    chk("id", ID_EXP, r);
    srpd_host_inst.xbyte(8'h00, r);
    chk("id again", ID_EXP, r);
    srpd_host_inst.desel();
    $display("test power-down done");
  endtask : t_dpd
  task t_lock;
    lock_blow = 1'b1;
    cyc(1);
    lock_blow = 1'b0;
    cyc(4);
    prog(24'h000000, 8'h00, 1'b1);
    chk("locked", 8'h16, st);
    rd(24'h000000, 8'h3C, 8'hFF);
    srpd_host_inst.cmd(8'hB9);
    cyc(180);
    chk("pd", 8'h0E, st);
    soft_rst = 1'b1;
    cyc(1);
    soft_rst = 1'b0;
    chk("soft reset", 8'h16, st);
    $display("test lock done");
  endtask : t_lock
  task results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  initial begin
    nrst       = 1'b0;
    ext_busy   = 1'b0;
    lock_blow  = 1'b0;
    soft_rst   = 1'b0;
    fuse       = 1'b0;
    mismatches = 0;
    checks     = 0;
    repeat (12) @(posedge clk);
    #1 nrst = 1'b1;
    t_reset();
    t_prog();
    t_addr();
    t_dpd();
    t_lock();
    results();
  end
  initial begin
    #1500000;
    mismatches++;
    results();
  end
endmodule : tb_top
